// *** hw/ebt_timer8.sv ***
// Eight-bit down counter/timer with demodulation capture and Wishbone registers.
// What this block does
// - Writing enable one starts the counter.
// - Mode zero reloads at terminal; one stops.
// - Terminal count sets timeout; write one clears.
// - First count period after enable may be short.
// - Clock select picks the count tick rate.
// - Demod rising edge captures low, falling high.
// - Capture sets edge flag; D2 enables interrupt.
// - After capture, reload all ones and count.
// - Demod terminal sets timeout, continues from ones.
// - Timeout interrupt only when D1 is set.
// - Sync mode gives first carrier pulse full width.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module ebt_timer8 (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic sixteenBitTimerDemod,
    input wire logic demodPin,
    input wire logic portLatch,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic port3Bit4Pin,
    output logic irq
);
    typedef enum logic [1:0] {IDLE, WAIT_SYNC, RUN} ebt_run_type;
    typedef struct packed {
        logic [7:0] ctlA;
        logic [7:0] ctlB;
        logic [7:0] ctl16;
        logic [7:0] init;
        logic [7:0] count;
        logic [7:0] lowHold;
        logic [7:0] highHold;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        ebt_run_type run;
        logic carrier;
        logic [7:0] datOut;
        logic ack;
        logic pinOut;
        logic irq;
    } ebt_state_type;
    ebt_state_type state_reg;
    ebt_state_type state_next;
    ebt_tick_if tk ();
    logic demodLevel;
    logic demodRise;
    logic demodFall;
    logic t16Rise;
    logic t16Level;
    logic unusedFall;

    ebt_prescaler u_pre (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tk(tk.source)
    );
    ebt_pin_sync u_demod (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(demodPin),
        .level(demodLevel),
        .rise(demodRise),
        .fall(demodFall)
    );
    ebt_pin_sync u_t16 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(sixteenBitTimerDemod),
        .level(t16Level),
        .rise(t16Rise),
        .fall(unusedFall)
    );

    function automatic logic [7:0] ebt_w1c(input logic [7:0] cur, input logic [7:0] wr,
                                           input logic [7:0] mask);
        ebt_w1c = cur & ~(wr & mask);
    endfunction

    logic wbReq;
    logic wbWr;
    assign wbReq = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign wbWr = wbReq && wb_we_i && wb_sel_i;
    assign tk.sel = state_reg.ctlA[ebt_pkg::A_CLKSEL_LO +: 2];
    assign tk.restart = (state_reg.run == WAIT_SYNC);

    always_comb begin
        logic terminal;
        logic capture;
        logic evTimeout;
        logic evPos;
        logic evNeg;
        logic demod;
        logic [7:0] w1cA;
        logic [7:0] w1cB;
        terminal = 1'b0;
        capture = 1'b0;
        evTimeout = 1'b0;
        evPos = 1'b0;
        evNeg = 1'b0;
        demod = state_reg.ctlB[ebt_pkg::B_DEMOD];
        w1cA = ebt_w1c(state_reg.ctlA, wb_dat_i, 8'h20);
        w1cB = ebt_w1c(state_reg.ctlB, wb_dat_i, 8'h03);
        state_next = state_reg;
        state_next.ack = wbReq;
        // Register writes happen first so hardware events below win over clears.
        if (wbWr) begin
            if (wb_adr_i == ebt_pkg::OFF_CONTROL_A) begin
                state_next.ctlA = {wb_dat_i[7:6], w1cA[5], wb_dat_i[4:0]};
            end else if (wb_adr_i == ebt_pkg::OFF_CONTROL_B) begin
                state_next.ctlB = {wb_dat_i[7:2], w1cB[1:0]};
            end else if (wb_adr_i == ebt_pkg::OFF_TIMER16_CTL) begin
                state_next.ctl16 = wb_dat_i;
            end else if (wb_adr_i == ebt_pkg::OFF_INIT) begin
                state_next.init = wb_dat_i;
            end else if (wb_adr_i == ebt_pkg::OFF_IRQ_STATUS) begin
                state_next.irqStat = state_reg.irqStat & ~wb_dat_i[2:0];
            end else if (wb_adr_i == ebt_pkg::OFF_IRQ_MASK) begin
                state_next.irqMask = wb_dat_i[2:0];
            end
        end
        // Enable rising from software starts the run; clearing it stops.
        if (!state_next.ctlA[ebt_pkg::A_ENABLE]) begin
            state_next.run = IDLE;
        end else begin
            case (state_reg.run)
                IDLE: begin
                    state_next.count = demod ? ebt_pkg::COUNT_ALL_ONES : state_next.init;
                    // Without sync the prescaler phase is free, so the first tick may be short.
                    state_next.run = state_reg.ctl16[ebt_pkg::C_SYNC] ? WAIT_SYNC : RUN;
                end
                WAIT_SYNC: begin
                    if (t16Rise) begin
                        state_next.run = RUN;
                        state_next.carrier = 1'b1;
                    end
                end
                RUN: begin
                    if (demod && (demodRise || demodFall)) begin
                        capture = 1'b1;
                        state_next.count = ebt_pkg::COUNT_ALL_ONES;
                        if (demodRise) begin
                            state_next.lowHold = state_reg.count;
                            evPos = 1'b1;
                        end else begin
                            state_next.highHold = state_reg.count;
                            evNeg = 1'b1;
                        end
                    end else if (tk.tick) begin
                        if (state_reg.count == ebt_pkg::COUNT_TERMINAL) begin
                            terminal = 1'b1;
                        end else begin
                            state_next.count = state_reg.count - 8'h01;
                        end
                    end
                    if (terminal) begin
                        evTimeout = 1'b1;
                        state_next.carrier = !state_reg.carrier;
                        if (demod) begin
                            state_next.count = ebt_pkg::COUNT_ALL_ONES;
                        end else if (state_reg.ctlA[ebt_pkg::A_SINGLE]) begin
                            state_next.ctlA[ebt_pkg::A_ENABLE] = 1'b0;
                            state_next.run = IDLE;
                        end else begin
                            state_next.count = state_reg.init;
                        end
                    end
                end
                default: state_next.run = IDLE;
            endcase
        end
        if (evTimeout) begin
            state_next.ctlA[ebt_pkg::A_TIMEOUT] = 1'b1;
            state_next.irqStat[ebt_pkg::IRQ_TIMEOUT] = 1'b1;
        end
        if (evPos) begin
            state_next.ctlB[ebt_pkg::B_EDGE_POS] = 1'b1;
            state_next.irqStat[ebt_pkg::IRQ_POS] = 1'b1;
        end
        if (evNeg) begin
            state_next.ctlB[ebt_pkg::B_EDGE_NEG] = 1'b1;
            state_next.irqStat[ebt_pkg::IRQ_NEG] = 1'b1;
        end
        // Both the enable bits in control A and the mask register must pass an event.
        state_next.irq = (state_next.irqStat[ebt_pkg::IRQ_TIMEOUT]
                          && state_next.ctlA[ebt_pkg::A_TIMEOUT_IE]
                          && state_next.irqMask[ebt_pkg::IRQ_TIMEOUT])
                         || (|state_next.irqStat[2:1] && state_next.ctlA[ebt_pkg::A_EDGE_IE]
                             && |(state_next.irqStat[2:1] & state_next.irqMask[2:1]));
        state_next.pinOut = state_next.ctlA[ebt_pkg::A_ROUTE] ? state_next.carrier : portLatch;
        state_next.datOut = 8'h00;
        if (wbReq && !wb_we_i) begin
            if (wb_adr_i == ebt_pkg::OFF_CONTROL_A) begin
                state_next.datOut = state_reg.ctlA;
            end else if (wb_adr_i == ebt_pkg::OFF_CONTROL_B) begin
                state_next.datOut = state_reg.ctlB;
            end else if (wb_adr_i == ebt_pkg::OFF_TIMER16_CTL) begin
                state_next.datOut = state_reg.ctl16;
            end else if (wb_adr_i == ebt_pkg::OFF_INIT) begin
                state_next.datOut = state_reg.init;
            end else if (wb_adr_i == ebt_pkg::OFF_COUNT) begin
                state_next.datOut = state_reg.count;
            end else if (wb_adr_i == ebt_pkg::OFF_LOW_HOLD) begin
                state_next.datOut = state_reg.lowHold;
            end else if (wb_adr_i == ebt_pkg::OFF_HIGH_HOLD) begin
                state_next.datOut = state_reg.highHold;
            end else if (wb_adr_i == ebt_pkg::OFF_IRQ_STATUS) begin
                state_next.datOut = {5'h00, state_reg.irqStat};
            end else if (wb_adr_i == ebt_pkg::OFF_IRQ_MASK) begin
                state_next.datOut = {5'h00, state_reg.irqMask};
            end
        end
        if (capture && demodLevel && t16Level) begin
            state_next.carrier = state_reg.carrier;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o = state_reg.datOut;
    assign wb_ack_o = state_reg.ack;
    assign port3Bit4Pin = state_reg.pinOut;
    assign irq = state_reg.irq;
endmodule

// *** pkg/ebt_pkg.sv ***
// Package with register map, field positions and reset values of the 8-bit counter/timer.
package ebt_pkg;
    localparam logic [3:0] OFF_CONTROL_A = 4'h0;
    localparam logic [3:0] OFF_CONTROL_B = 4'h1;
    localparam logic [3:0] OFF_TIMER16_CTL = 4'h3;
    localparam logic [3:0] OFF_INIT = 4'h4;
    localparam logic [3:0] OFF_COUNT = 4'h5;
    localparam logic [3:0] OFF_LOW_HOLD = 4'h6;
    localparam logic [3:0] OFF_HIGH_HOLD = 4'h7;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h9;
    // Control A fields.
    localparam int A_ENABLE = 7;
    localparam int A_SINGLE = 6;
    localparam int A_TIMEOUT = 5;
    localparam int A_CLKSEL_LO = 3;
    localparam int A_EDGE_IE = 2;
    localparam int A_TIMEOUT_IE = 1;
    localparam int A_ROUTE = 0;
    // Control B fields.
    localparam int B_DEMOD = 7;
    localparam int B_EDGE_NEG = 1;
    localparam int B_EDGE_POS = 0;
    // Timer8/timer16 control fields.
    localparam int C_SYNC = 0;
    // Interrupt status and mask bits.
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_POS = 1;
    localparam int IRQ_NEG = 2;
    localparam logic [7:0] RESET_CONTROL_A = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_ALL_ONES = 8'hff;
    localparam logic [7:0] COUNT_TERMINAL = 8'h00;
    // Prescale divide ratios for clock select 0..3, as cycles minus one.
    localparam logic [7:0] DIV_SEL0 = 8'h01;
    localparam logic [7:0] DIV_SEL1 = 8'h03;
    localparam logic [7:0] DIV_SEL2 = 8'h07;
    localparam logic [7:0] DIV_SEL3 = 8'h0f;
endpackage

// *** pkg/ebt_tick_if.sv ***
// Interface carrying the prescaler tick between prescaler and counter core.
`timescale 1ns/100ps
interface ebt_tick_if;
    logic [1:0] sel;
    logic restart;
    logic tick;
    modport source (input sel, input restart, output tick);
    modport sink (output sel, output restart, input tick);
endinterface

// *** hw/ebt_prescaler.sv ***
// Prescaler that divides the core clock into the selected count tick.
`timescale 1ns/100ps
module ebt_prescaler (
    input wire logic core_clk,
    input wire logic rst_n,
    ebt_tick_if.source tk
);
    typedef struct packed {
        logic [7:0] div;
        logic tick;
    } ebt_pre_type;
    ebt_pre_type state_reg;
    ebt_pre_type state_next;

    function automatic logic [7:0] ebt_limit(input logic [1:0] sel);
        case (sel)
            2'h0: ebt_limit = ebt_pkg::DIV_SEL0;
            2'h1: ebt_limit = ebt_pkg::DIV_SEL1;
            2'h2: ebt_limit = ebt_pkg::DIV_SEL2;
            default: ebt_limit = ebt_pkg::DIV_SEL3;
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        // Restart lets sync mode give the first period full width.
        if (tk.restart) begin
            state_next.div = ebt_pkg::RESET_BYTE;
        end else if (state_reg.div >= ebt_limit(tk.sel)) begin
            state_next.div = ebt_pkg::RESET_BYTE;
            state_next.tick = 1'b1;
        end else begin
            state_next.div = state_reg.div + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tk.tick = state_reg.tick;
endmodule

// *** hw/ebt_pin_sync.sv ***
// Three-stage synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
module ebt_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
        logic rise;
        logic fall;
    } ebt_sync_type;
    ebt_sync_type state_reg;
    ebt_sync_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage = {state_reg.stage[1:0], pinIn};
        state_next.rise = 1'b0;
        state_next.fall = 1'b0;
        // Only stages two and three are compared; stage one feeds stage two alone.
        if (state_reg.stage[1] == state_reg.stage[2] && state_reg.stage[2] != state_reg.level) begin
            state_next.level = state_reg.stage[2];
            state_next.rise = state_reg.stage[2];
            state_next.fall = !state_reg.stage[2];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;
    assign rise = state_reg.rise;
    assign fall = state_reg.fall;
endmodule

// *** dv/ebt_timer8_properties.sv ***
// Checker of bus handshake, read data and interrupt behaviour of the 8-bit timer.
`timescale 1ns/100ps
module ebt_timer8_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_gap;
        req_taken ##1 wb_ack_o ##1 req_taken;
    endsequence
    ack_answer_a: assert property (req_taken |=> wb_ack_o) else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_again_a: assert property (ack_gap |=> wb_ack_o) else $error("second request not acked");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 8'h00) else $error("data outside ack");
    dat_change_a: assert property ($changed(wb_dat_o) |-> wb_ack_o || $past(wb_ack_o))
        else $error("data moved without ack");
    unmapped_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i > 4'h9 |=> wb_dat_o == 8'h00) else $error("unmapped read not zero");
    irq_clear_a: assert property ($fell(irq) |-> (wb_ack_o && wb_we_i)
        || $past(wb_ack_o && wb_we_i)) else $error("irq fell without a write");
endmodule
bind ebt_timer8 ebt_timer8_properties chk (.core_clk(core_clk), .rst_n(rst_n),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

// *** dv/ebt_pulse_model.sv ***
// Behavioural source of the demodulation pin and the 16-bit timer carrier.
`timescale 1ns/100ps
module ebt_pulse_model (
    input wire logic core_clk,
    output logic demodPin,
    output logic carrier16
);
    initial begin
        demodPin = 1'b0;
        carrier16 = 1'b0;
    end
    // Levels move just after an edge and hold for whole cycles, as a real pin would.
    task automatic drive_demod(input logic lvl, input int waitCyc);
        repeat (waitCyc) @(posedge core_clk);
        demodPin <= lvl;
    endtask
    task automatic drive_carrier(input logic lvl);
        @(posedge core_clk);
        carrier16 <= lvl;
    endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench of the 8-bit counter/timer.
`timescale 1ns/100ps
module tb_top;
    localparam logic [3:0] CA = ebt_pkg::OFF_CONTROL_A;
    localparam logic [3:0] CB = ebt_pkg::OFF_CONTROL_B;
    localparam logic [3:0] ST = ebt_pkg::OFF_IRQ_STATUS;
    localparam logic [3:0] MK = ebt_pkg::OFF_IRQ_MASK;
    localparam logic [3:0] IV = ebt_pkg::OFF_INIT;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [7:0] wdat = 8'h00;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic portLatch = 1'b1;
    logic [7:0] rdat;
    logic [7:0] rdat_hold;
    logic ack, pin34, irq, demodPin, carrier16;
    int error_cnt = 0;
    int checks = 0;
    int cycCnt = 0;
    ebt_timer8 DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .sixteenBitTimerDemod(carrier16), .demodPin(demodPin), .portLatch(portLatch),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port3Bit4Pin(pin34), .irq(irq));
    ebt_pulse_model pm (.core_clk(core_clk), .demodPin(demodPin), .carrier16(carrier16));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks++;
        if (^got === 1'bx || got < lo || got > hi) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk({7'h0, ack}, 8'h01, 8'h01);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e, e);
    endtask
    task automatic wait_irq(output int t);
        logic pv;
        int n;
        n = 0;
        do begin
            pv = irq;
            @(posedge core_clk);
            n++;
        end while (!(pv === 1'b0 && irq === 1'b1) && n < 2000);
        t = cycCnt;
        chk({7'h0, irq}, 8'h01, 8'h01);
    endtask
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge core_clk);
        chk({7'h0, irq}, {7'h0, e}, {7'h0, e});
    endtask
    task automatic arm(input logic [7:0] iv, input logic [7:0] mk);
        wr(CA, 8'h20);
        wr(ST, 8'h07);
        wr(IV, iv);
        wr(MK, mk);
    endtask
    task automatic t_reset();
        rd(CA, ebt_pkg::RESET_CONTROL_A);
        rd(CB, 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        rd(4'h2, 8'h00);
    endtask
    task automatic t_modulo();
        int t1, t2;
        for (int s = 0; s < 4; s++) begin
            arm(8'h05, 8'h01);
            wr(CA, 8'h82 | 8'(s << 3));
            wait_irq(t1);
            wr(ST, 8'h01);
            wait_irq(t2);
            chk(8'(t2 - t1), 8'(6 << (s + 1)), 8'(6 << (s + 1)));
        end
    endtask
    task automatic t_single();
        arm(8'h03, 8'h01);
        wr(CA, 8'hc0);
        repeat (40) @(posedge core_clk);
        rd(CA, 8'h60);
        chk_irq(1'b0);
        chk({7'h0, pin34}, 8'h01, 8'h01);
        wr(CA, 8'h40);
        rd(CA, 8'h60);
        wr(CA, 8'h42);
        chk_irq(1'b1);
        wr(CA, 8'h62);
        rd(CA, 8'h42);
        chk_irq(1'b1);
        wr(ST, 8'h01);
        chk_irq(1'b0);
        rd(ST, 8'h00);
    endtask
    task automatic t_demod();
        arm(8'h10, 8'h06);
        wr(CB, 8'h80);
        wr(CA, 8'h84);
        pm.drive_demod(1'b1, 5);
        pm.drive_demod(1'b0, 40);
        pm.drive_demod(1'b1, 60);
        repeat (6) @(posedge core_clk);
        wr(CA, 8'h04);
        rd(CB, 8'h83);
        rd(ST, 8'h06);
        chk_irq(1'b1);
        wb(1'b0, ebt_pkg::OFF_HIGH_HOLD, 8'h00, rdat_hold);
        chk(rdat_hold, 8'he9, 8'hed);
        wb(1'b0, ebt_pkg::OFF_LOW_HOLD, 8'h00, rdat_hold);
        chk(rdat_hold, 8'hdf, 8'he3);
        wr(CB, 8'h83);
        rd(CB, 8'h80);
        wr(ST, 8'h06);
        chk_irq(1'b0);
        wr(CA, 8'h84);
        repeat (600) @(posedge core_clk);
        rd(CA, 8'ha4);
        pm.drive_demod(1'b0, 1);
        wr(CB, 8'h00);
    endtask
    task automatic t_sync();
        int t0, t1;
        arm(8'h02, 8'h01);
        wr(ebt_pkg::OFF_TIMER16_CTL, 8'h01);
        wr(CA, 8'h83);
        repeat (50) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00, 8'h00);
        pm.drive_carrier(1'b1);
        t0 = cycCnt;
        wait_irq(t1);
        chk(8'(t1 - t0), 8'h06, 8'h0e);
        chk({7'h0, pin34}, 8'h00, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_modulo();
        t_single();
        t_demod();
        t_sync();
        tally_and_finish();
    end
endmodule
